// ### src/scp_map.svh
// Constants of the serial control port: offsets, field positions, timing
`ifndef SCP_MAP_SVH
`define SCP_MAP_SVH

// ==========================================================
// Device register offsets
`define SCP_REG_CFG        14'h0000
`define SCP_REG_RBSEL      14'h0001
`define SCP_REG_XFER       14'h000F
`define SCP_REG_DRIVE      14'h0109

// ==========================================================
// Field positions, reset value, counter limits and strap settings
`define SCP_CFG_4WIRE_BIT  4
`define SCP_CFG_ASCEND_BIT 5
`define SCP_CFG_LSB_BIT    6
`define SCP_RBSEL_BUF_BIT  5
`define SCP_XFER_UPD_BIT   0
`define SCP_DRIVE_BIT      7
`define SCP_REG_RESET      8'h00
`define SCP_INSTR_LAST     4'hF
`define SCP_BYTE_LAST      3'h7
`define SCP_STRAP_SPI      1'b0
`define SCP_STRAP_WAIT     2'h3

// ==========================================================
// Controller register offsets (byte addresses), control bits and shift lengths
`define SCP_AV_INSTR       4'h0
`define SCP_AV_DATA        4'h4
`define SCP_AV_CTRL        4'h8
`define SCP_AV_STAT        4'hC
`define SCP_CTRL_GO_BIT    0
`define SCP_CTRL_LAST_BIT  1
`define SCP_CTRL_LSB_BIT   2
`define SCP_CTRL_FOUR_BIT  3
`define SCP_INSTR_NBITS    5'h18
`define SCP_BYTE_NBITS     5'h08

// ==========================================================
// Timing
`define SCP_CLK_NS         40
`define SCP_SCLK_HALF_NS   160
`define SCP_SCLK_HALF_CYC  ((`SCP_SCLK_HALF_NS + `SCP_CLK_NS - 1) / `SCP_CLK_NS)

`endif

// ### src/scp_pkg.sv
// State types of the serial control port, one for each end
package scp_pkg;

    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_INSTR,
        DEV_DATA
    } scp_dst_t;

    typedef enum logic [2:0] {
        HST_IDLE,
        HST_LOW,
        HST_HIGH,
        HST_END,
        HST_GAP
    } scp_hst_t;

endpackage : scp_pkg

// ### src/scp_if.sv
// Link between controller and device: serial clock, select, data lines
`timescale 1ns/10ps
`default_nettype none

interface scp_if;
    logic sclk;
    logic cs_n;
    logic h_sdio_o;
    logic h_sdio_oe_n;
    logic d_sdio_o;
    logic d_sdio_oe_n;
    logic d_sdo_o;
    logic d_sdo_oe_n;
    logic sdio_line;
    logic sdo_line;

    // ==========================================================
    // Line levels; an undriven line floats high on its pull-up
    assign sdio_line = !d_sdio_oe_n ? d_sdio_o : (!h_sdio_oe_n ? h_sdio_o : 1'b1);
    assign sdo_line  = !d_sdo_oe_n ? d_sdo_o : 1'b1;

    modport dev  (input sclk, cs_n, sdio_line,
                  output d_sdio_o, d_sdio_oe_n, d_sdo_o, d_sdo_oe_n);
    modport host (output sclk, cs_n, h_sdio_o, h_sdio_oe_n,
                  input sdio_line, sdo_line);
endinterface : scp_if

`default_nettype wire

// ### src/scp_sync.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module scp_sync #(
    parameter int W = 1
) (
    input  wire logic         ref_clk_i,
    input  wire logic         nrst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] q;
    } scp_sync_t;

    scp_sync_t r, n;

    always_comb begin
        n      = r;
        n.meta = d_i;
        n.q    = r.meta;
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign q_o = r.q;
endmodule : scp_sync

`default_nettype wire

// ### src/scp_dev.sv
// Device end: serial control port slave with buffer and active registers
// ==========================================================
// Overview of operation
// - Transfer ends only when select rises
// - Address steps each byte per direction bit
// - Strap at startup picks protocol until reset
// - Sample input rising, launch output falling
// - Three-wire default, four-wire by config bit
// - MSB-first default, bit 6 selects LSB-first
// - Bit 7 of 0x109 selects drive strength
// - Select falling starts a new instruction
// - Host raises select after last byte
// - Both data outputs released while deselected
// - Sixteen-bit instruction, then payload bits
// - Top bit read/write, then 15-bit address
// - Top address bit ignored, treated zero
// - Writes land in buffer registers; config also goes active at once
// - Strobe copies all buffers to active
// - Transfer bit 0 strobes, clears itself
// - Configured multipurpose pin high also strobes
// - Reads stream bytes, blanks included, per mode
// - Readback source chosen by bit 5
// - Host captures read bits on falling edge
// - Host writes zeros into blank registers
// - Bit 5 zero steps down, one up
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

module scp_dev #(
    parameter int NREG = 512
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    scp_if.dev               lnk,
    input  wire logic        protocol_strap_pin_i,
    input  wire logic        multipurpose_pin_i,
    input  wire logic        multipurpose_update_en_i,
    input  wire logic [13:0] act_addr_i,
    output logic      [7:0]  act_data_o,
    output logic             update_o,
    output logic             drive_strong_o,
    output logic             spi_active_o
);
    localparam int AW = $clog2(NREG);

    typedef logic [NREG-1:0][7:0] scp_mem_t;

    typedef struct packed {
        scp_pkg::scp_dst_t st;
        logic [3:0]        bcnt;
        logic [2:0]        fcnt;
        logic [15:0]       sh;
        logic [13:0]       addr;
        logic              rw;
        logic [7:0]        tx;
        logic              sclk_q;
        logic              cs_q;
        logic [1:0]        strap_cnt;
        logic              spi_on;
        logic              sdio_o;
        logic              sdio_oe_n;
        logic              sdo_o;
        logic              sdo_oe_n;
        logic              upd_o;
        logic              drive_o;
        logic [7:0]        act_data_o;
        scp_mem_t          bufm;
        scp_mem_t          actm;
    } scp_dreg_t;

    scp_dreg_t   r, n;
    logic [4:0]  pin_s;
    logic        sclk_s, cs_s, sdi_s, mp_s, strap_s;
    logic        rise, fall, lsb, up, four, upd, obit, wr_v;
    logic [15:0] wrd;
    logic [7:0]  byte_v;
    logic [13:0] nxt_a;

    // ==========================================================
    // Pin synchronisers
    scp_sync #(.W(5)) u_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .d_i       ({lnk.sclk, lnk.cs_n, lnk.sdio_line, multipurpose_pin_i,
                     protocol_strap_pin_i}),
        .q_o       (pin_s)
    );
    assign {sclk_s, cs_s, sdi_s, mp_s, strap_s} = pin_s;

    // ==========================================================
    // Helpers
    function automatic logic [15:0] shin(input logic [15:0] s, input logic b,
                                         input logic l);
        shin = l ? {b, s[15:1]} : {s[14:0], b};
    endfunction : shin

    function automatic logic [13:0] step(input logic [13:0] a, input logic u);
        step = u ? a + 14'h0001 : a - 14'h0001;
    endfunction : step

    function automatic logic [7:0] rd_byte(input logic [13:0] a, input scp_dreg_t s);
        rd_byte = 8'h00;
        if (a != `SCP_REG_XFER && a < 14'(NREG)) begin
            // Readback from buffer or active copy
            rd_byte = s.bufm[`SCP_REG_RBSEL][`SCP_RBSEL_BUF_BIT] ? s.bufm[a[AW-1:0]]
                                                                  : s.actm[a[AW-1:0]];
        end
    endfunction : rd_byte

    // ==========================================================
    // Next state
    always_comb begin
        n      = r;
        rise   = sclk_s & ~r.sclk_q;
        fall   = ~sclk_s & r.sclk_q;
        lsb    = r.actm[`SCP_REG_CFG][`SCP_CFG_LSB_BIT];
        up     = r.actm[`SCP_REG_CFG][`SCP_CFG_ASCEND_BIT];
        four   = r.actm[`SCP_REG_CFG][`SCP_CFG_4WIRE_BIT];
        wrd    = shin(r.sh, sdi_s, lsb);
        nxt_a  = step(r.addr, up);
        byte_v = lsb ? wrd[15:8] : wrd[7:0];
        obit   = r.tx[lsb ? r.fcnt : 3'h7 - r.fcnt];
        upd    = 1'b0;
        wr_v   = 1'b0;
        n.sclk_q = sclk_s;
        n.cs_q   = cs_s;
        n.upd_o  = 1'b0;

        // Strap is sampled for three cycles after reset; the last sample, taken once the synchroniser has settled, is kept
        if (r.strap_cnt != `SCP_STRAP_WAIT) begin
            n.strap_cnt = r.strap_cnt + 2'h1;
            n.spi_on    = (strap_s == `SCP_STRAP_SPI);
        end

        if (cs_s || !r.spi_on || r.strap_cnt != `SCP_STRAP_WAIT) begin
            n.st        = scp_pkg::DEV_IDLE;
            n.bcnt      = '0;
            n.fcnt      = '0;
            n.sdio_oe_n = 1'b1;
            n.sdo_oe_n  = 1'b1;
        end else if (r.cs_q) begin
            n.st   = scp_pkg::DEV_INSTR;
            n.bcnt = '0;
        end else if (rise && r.st == scp_pkg::DEV_INSTR) begin
            n.sh   = wrd;
            n.bcnt = r.bcnt + 4'h1;
            if (r.bcnt == `SCP_INSTR_LAST) begin
                n.rw   = wrd[15];
                n.addr = wrd[13:0];
                n.tx   = rd_byte(wrd[13:0], r);
                n.st   = scp_pkg::DEV_DATA;
                n.bcnt = '0;
                n.fcnt = '0;
            end
        end else if (rise && r.st == scp_pkg::DEV_DATA) begin
            n.sh   = wrd;
            n.bcnt = {1'b0, r.bcnt[2:0] + 3'h1};
            if (r.bcnt[2:0] == `SCP_BYTE_LAST) begin
                n.addr = nxt_a;
                n.bcnt = '0;
                if (r.rw) begin
                    n.tx = rd_byte(nxt_a, r);
                end else begin
                    wr_v = 1'b1;
                end
            end
        end else if (fall && r.st == scp_pkg::DEV_DATA && r.rw) begin
            n.sdio_o    = obit;
            n.sdo_o     = obit;
            n.sdio_oe_n = four;
            n.sdo_oe_n  = ~four;
            n.fcnt      = r.fcnt + 3'h1;
        end

        // Byte commit: buffer only, except the port config which acts at once
        if (wr_v) begin
            if (r.addr == `SCP_REG_XFER) begin
                upd = byte_v[`SCP_XFER_UPD_BIT];
            end else if (r.addr < 14'(NREG)) begin
                n.bufm[r.addr[AW-1:0]] = byte_v;
                if (r.addr == `SCP_REG_CFG) begin
                    n.actm[r.addr[AW-1:0]] = byte_v;
                end
            end
        end

        if (upd || (mp_s && multipurpose_update_en_i)) begin
            n.actm  = n.bufm;
            n.upd_o = 1'b1;
        end

        n.drive_o    = r.actm[`SCP_REG_DRIVE][`SCP_DRIVE_BIT];
        n.act_data_o = (act_addr_i < 14'(NREG)) ? r.actm[act_addr_i[AW-1:0]]
                                                : `SCP_REG_RESET;
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r           <= '0;
            r.sdio_oe_n <= 1'b1;
            r.sdo_oe_n  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ==========================================================
    // Outputs
    assign lnk.d_sdio_o    = r.sdio_o;
    assign lnk.d_sdio_oe_n = r.sdio_oe_n;
    assign lnk.d_sdo_o     = r.sdo_o;
    assign lnk.d_sdo_oe_n  = r.sdo_oe_n;
    assign act_data_o      = r.act_data_o;
    assign update_o        = r.upd_o;
    assign drive_strong_o  = r.drive_o;
    assign spi_active_o    = r.spi_on;
endmodule : scp_dev

`default_nettype wire

// ### src/scp_host.sv
// Controller end: Avalon-MM registers driving the serial link as master
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

module scp_host #(
    parameter int HALF = `SCP_SCLK_HALF_CYC
) (
    input  wire logic        ref_clk_i,
    input  wire logic        nrst_i,
    scp_if.host              lnk,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o
);
    typedef struct packed {
        scp_pkg::scp_hst_t st;
        logic [7:0]        cnt;
        logic [4:0]        nbits;
        logic [23:0]       tx;
        logic [7:0]        rx;
        logic [15:0]       instr;
        logic [7:0]        data;
        logic              last;
        logic              lsb;
        logic              four;
        logic              open;
        logic              rd;
        logic              sclk;
        logic              cs_n;
        logic              mosi;
        logic              oe_n;
        logic              wait_r;
        logic [31:0]       rdata;
    } scp_hreg_t;

    scp_hreg_t   r, n;
    logic [1:0]  in_s;
    logic        miso;
    logic [15:0] o16;
    logic [15:0] o8;

    scp_sync #(.W(2)) u_sync (
        .ref_clk_i (ref_clk_i),
        .nrst_i    (nrst_i),
        .d_i       ({lnk.sdio_line, lnk.sdo_line}),
        .q_o       (in_s)
    );

    function automatic logic [15:0] ord(input logic [15:0] v, input logic l);
        ord = v;
        if (l) begin
            for (int i = 0; i < 16; i++) begin
                ord[i] = v[15-i];
            end
        end
    endfunction : ord

    // ==========================================================
    // Next state
    always_comb begin
        n        = r;
        miso     = r.four ? in_s[0] : in_s[1];
        o16      = ord(r.instr, avs_writedata_i[`SCP_CTRL_LSB_BIT]);
        o8       = ord({r.data, r.data}, avs_writedata_i[`SCP_CTRL_LSB_BIT]);
        n.wait_r = 1'b1;

        // One wait cycle; a write acts at the edge where wait is low
        if ((avs_read_i || avs_write_i) && r.wait_r) begin
            n.wait_r = 1'b0;
            unique case (avs_address_i)
                `SCP_AV_INSTR: n.rdata = {16'h0000, r.instr};
                `SCP_AV_DATA:  n.rdata = {24'h000000, r.rx};
                `SCP_AV_STAT:  n.rdata = {30'h0, r.open, r.st != scp_pkg::HST_IDLE};
                default:       n.rdata = 32'h00000000;
            endcase
        end
        if (avs_write_i && !r.wait_r) begin
            if (avs_address_i == `SCP_AV_INSTR && r.st == scp_pkg::HST_IDLE) begin
                n.instr = avs_writedata_i[15:0];
            end
            if (avs_address_i == `SCP_AV_DATA && r.st == scp_pkg::HST_IDLE) begin
                n.data = avs_writedata_i[7:0];
            end
            if (avs_address_i == `SCP_AV_CTRL && r.st == scp_pkg::HST_IDLE
                && avs_writedata_i[`SCP_CTRL_GO_BIT]) begin
                n.last = avs_writedata_i[`SCP_CTRL_LAST_BIT];
                n.lsb  = avs_writedata_i[`SCP_CTRL_LSB_BIT];
                n.four = avs_writedata_i[`SCP_CTRL_FOUR_BIT];
                n.st   = scp_pkg::HST_LOW;
                n.cnt  = 8'(HALF - 1);
                n.sclk = 1'b0;
                if (!r.open) begin
                    n.open  = 1'b1;
                    n.cs_n  = 1'b0;
                    n.rd    = r.instr[15];
                    n.tx    = {o16, o8[7:0]};
                    n.nbits = `SCP_INSTR_NBITS;
                    n.mosi  = o16[15];
                    n.oe_n  = 1'b0;
                end else begin
                    n.tx    = {o8[7:0], 16'h0000};
                    n.nbits = `SCP_BYTE_NBITS;
                    n.mosi  = o8[7];
                end
            end
        end

        // ==========================================================
        // Serial clock divider and shifter
        unique case (r.st)
            scp_pkg::HST_IDLE: begin
            end
            scp_pkg::HST_LOW: begin
                n.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    n.sclk = 1'b1;
                    n.st   = scp_pkg::HST_HIGH;
                    n.cnt  = 8'(HALF - 1);
                end
            end
            scp_pkg::HST_HIGH: begin
                n.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    if (r.rd && r.nbits <= `SCP_BYTE_NBITS) begin
                        n.rx = r.lsb ? {miso, r.rx[7:1]} : {r.rx[6:0], miso};
                    end
                    n.sclk  = 1'b0;
                    n.nbits = r.nbits - 5'h01;
                    n.tx    = {r.tx[22:0], 1'b0};
                    n.mosi  = r.tx[22];
                    n.cnt   = 8'(HALF - 1);
                    // Release the shared line for the device's read bytes
                    n.oe_n  = r.rd && !r.four && r.nbits <= `SCP_BYTE_NBITS + 5'd1;
                    n.st    = (r.nbits == 5'h01) ? scp_pkg::HST_END : scp_pkg::HST_LOW;
                end
            end
            scp_pkg::HST_END: begin
                n.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    n.st = scp_pkg::HST_IDLE;
                    if (r.last) begin
                        n.cs_n = 1'b1;
                        n.open = 1'b0;
                        n.oe_n = 1'b1;
                        n.st   = scp_pkg::HST_GAP;
                        n.cnt  = 8'(HALF - 1);
                    end
                end
            end
            scp_pkg::HST_GAP: begin
                // Deselect must last long enough for the device to see it
                n.cnt = r.cnt - 8'h01;
                if (r.cnt == 8'h00) begin
                    n.st = scp_pkg::HST_IDLE;
                end
            end
            default: n.st = scp_pkg::HST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            r        <= '0;
            r.cs_n   <= 1'b1;
            r.oe_n   <= 1'b1;
            r.wait_r <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign lnk.sclk          = r.sclk;
    assign lnk.cs_n          = r.cs_n;
    assign lnk.h_sdio_o      = r.mosi;
    assign lnk.h_sdio_oe_n   = r.oe_n;
    assign avs_readdata_o    = r.rdata;
    assign avs_waitrequest_o = r.wait_r;
endmodule : scp_host

`default_nettype wire

// ### verification/scp_link_chk.sv
// Checker of the serial link between controller and device
`timescale 1ns/10ps
`default_nettype none

module scp_link_chk #(
    parameter int HALF = 4
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic h_sdio_o,
    input wire logic h_sdio_oe_n,
    input wire logic d_sdio_o,
    input wire logic d_sdio_oe_n,
    input wire logic d_sdo_o,
    input wire logic d_sdo_oe_n
);
    logic [15:0] rise_cnt_r;
    logic [7:0]  hi_cnt_r;
    logic        sclk_d_r;

    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // ==========================================================
    // Edge counts per frame and width of the high phase
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rise_cnt_r <= 16'h0000;
            hi_cnt_r   <= 8'h00;
            sclk_d_r   <= 1'b0;
        end else begin
            sclk_d_r   <= sclk;
            hi_cnt_r   <= sclk ? hi_cnt_r + 8'h01 : 8'h00;
            rise_cnt_r <= cs_n ? 16'h0000 : rise_cnt_r + {15'h0000, sclk & ~sclk_d_r};
        end
    end

    // ==========================================================
    // Frame opening: clock held low one half period, then first rise
    sequence s_lead;
        !sclk [*4] ##1 sclk;
    endsequence
    sequence s_open;
        $fell(cs_n);
    endsequence

    // Device release is seen through its synchroniser, hence the margin
    AST_DESEL_SDIO: assert property (cs_n [*6] |-> d_sdio_oe_n)
        else $error("sdio driven while deselected");
    AST_DESEL_SDO: assert property (cs_n [*6] |-> d_sdo_oe_n)
        else $error("sdo driven while deselected");
    AST_NO_FIGHT: assert property (!(!d_sdio_oe_n && !h_sdio_oe_n))
        else $error("both ends drive sdio");
    AST_ONE_OUT: assert property (!(!d_sdio_oe_n && !d_sdo_oe_n))
        else $error("device drives both data lines");
    AST_IDLE_SCLK: assert property (cs_n |-> !sclk)
        else $error("clock moves outside a frame");
    AST_FRAME_OPEN: assert property (s_open |-> s_lead)
        else $error("frame start badly paced");
    AST_HOST_HOLD: assert property ((sclk && !h_sdio_oe_n) |-> $stable(h_sdio_o))
        else $error("host data moved while clock high");
    AST_DEV_LAUNCH: assert property ((!d_sdio_oe_n && $changed(d_sdio_o)) |-> !sclk)
        else $error("device sdio moved while clock high");
    AST_SDO_LAUNCH: assert property ((!d_sdo_oe_n && $changed(d_sdo_o)) |-> !sclk)
        else $error("device sdo moved while clock high");
    AST_HALF_HIGH: assert property ($fell(sclk) |-> hi_cnt_r == 8'(HALF))
        else $error("clock high phase wrong length");
    AST_FRAME_EDGES: assert property ($rose(cs_n) |->
        (rise_cnt_r >= 16'h0018 && rise_cnt_r[2:0] == 3'h0))
        else $error("frame not instruction plus whole bytes");
endmodule : scp_link_chk

`default_nettype wire

// ### verification/tb_top.sv
// Bench: controller and device joined, driven over Avalon-MM
`timescale 1ns/10ps
`default_nettype none
`include "scp_map.svh"

module tb_top;
    typedef struct packed {
        logic [7:0]  cfg;
        logic [15:0] ins;
        logic [7:0]  b0;
        logic [7:0]  b1;
        logic [13:0] e0;
        logic [13:0] e1;
    } scp_row_t;

    logic        ref_clk_i = 1'b0;
    logic        nrst_i    = 1'b0;
    logic [3:0]  av_addr   = 4'h0;
    logic        av_rd     = 1'b0;
    logic        av_wr     = 1'b0;
    logic [31:0] av_wdata  = 32'h0;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic        strap     = 1'b0;
    logic        mp_pin    = 1'b0;
    logic        mp_en     = 1'b0;
    logic [13:0] act_addr  = 14'h0000;
    logic [7:0]  act_data;
    logic        upd;
    logic        drv;
    logic        spi_act;
    logic [7:0]  cur_cfg   = 8'h00;
    logic [7:0]  rx;
    int          n_mismatch = 0;
    int          cmp_count  = 0;
    int          upd_n      = 0;
    int          upd_exp    = 0;
    scp_row_t    rows [5];

    scp_if lnk();

    scp_host #(.HALF(4)) i_scp_host (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .lnk(lnk),
        .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
        .avs_writedata_i(av_wdata), .avs_readdata_o(av_rdata), .avs_waitrequest_o(av_wait));
    scp_dev i_scp_dev (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .lnk(lnk),
        .protocol_strap_pin_i(strap), .multipurpose_pin_i(mp_pin),
        .multipurpose_update_en_i(mp_en), .act_addr_i(act_addr), .act_data_o(act_data),
        .update_o(upd), .drive_strong_o(drv), .spi_active_o(spi_act));
    scp_link_chk #(.HALF(4)) i_scp_link_chk (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i),
        .sclk(lnk.sclk), .cs_n(lnk.cs_n), .h_sdio_o(lnk.h_sdio_o),
        .h_sdio_oe_n(lnk.h_sdio_oe_n), .d_sdio_o(lnk.d_sdio_o),
        .d_sdio_oe_n(lnk.d_sdio_oe_n), .d_sdo_o(lnk.d_sdo_o), .d_sdo_oe_n(lnk.d_sdo_oe_n));

    always #20 ref_clk_i = ~ref_clk_i;
    // Counted on the falling edge so the registered pulse has settled
    always @(negedge ref_clk_i) if (upd === 1'b1) upd_n++;

    // ==========================================================
    // Compare, bus and link tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic chk_bit(input string nm, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk_bit

    task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge ref_clk_i);
        av_wr    <= wr;
        av_rd    <= ~wr;
        av_addr  <= a;
        av_wdata <= d;
        do @(posedge ref_clk_i); while (av_wait !== 1'b0);
        q = av_rdata;
        av_wr <= 1'b0;
        av_rd <= 1'b0;
    endtask : av

    // One byte on the link; the first in a frame carries the instruction
    task automatic xfer(input logic [15:0] ins, input logic [7:0] b, input logic last);
        logic [31:0] q;
        av(1'b1, `SCP_AV_INSTR, {16'h0000, ins}, q);
        av(1'b1, `SCP_AV_DATA, {24'h000000, b}, q);
        av(1'b1, `SCP_AV_CTRL, {28'h0000000, cur_cfg[4], cur_cfg[6], last, 1'b1}, q);
        do av(1'b0, `SCP_AV_STAT, 32'h0, q); while (q[0] !== 1'b0);
        av(1'b0, `SCP_AV_DATA, 32'h0, q);
        rx = q[7:0];
    endtask : xfer

    task automatic wreg(input logic [13:0] a, input logic [7:0] d);
        xfer({2'b00, a}, d, 1'b1);
    endtask : wreg

    task automatic rdreg(input logic [13:0] a, input logic [7:0] exp);
        xfer({2'b10, a}, 8'h00, 1'b1);
        chk("link read", {24'h0, exp}, {24'h0, rx});
    endtask : rdreg

    task automatic act(input logic [13:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        act_addr <= a;
        repeat (2) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk("active", {24'h0, exp}, {24'h0, act_data});
    endtask : act

    task automatic rst(input logic s);
        @(posedge ref_clk_i);
        strap  <= s;
        nrst_i <= 1'b0;
        repeat (3) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
    endtask : rst

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : stop_test

    // ==========================================================
    // Rows: config, instruction, two bytes, where they should land
    initial begin
        rows[0] = '{8'h00, 16'h0105, 8'h11, 8'h22, 14'h0105, 14'h0104};
        rows[1] = '{8'h20, 16'h4105, 8'h33, 8'h44, 14'h0105, 14'h0106};
        rows[2] = '{8'h30, 16'h0120, 8'h55, 8'h66, 14'h0120, 14'h0121};
        rows[3] = '{8'h60, 16'h0130, 8'hA5, 8'h3C, 14'h0130, 14'h0131};
        rows[4] = '{8'h00, 16'h0140, 8'h81, 8'h7E, 14'h0140, 14'h013F};
        rst(1'b0);
        chk_bit("spi active", 1'b1, spi_act);
        foreach (rows[i]) begin
            wreg(14'h0000, rows[i].cfg);
            cur_cfg = rows[i].cfg;
            xfer({1'b0, rows[i].ins[14:0]}, rows[i].b0, 1'b0);
            xfer({1'b0, rows[i].ins[14:0]}, rows[i].b1, 1'b1);
            wreg(`SCP_REG_XFER, 8'h01);
            upd_exp++;
            act(rows[i].e0, rows[i].b0);
            act(rows[i].e1, rows[i].b1);
            xfer({1'b1, rows[i].ins[14:0]}, 8'h00, 1'b0);
            chk("stream read 0", {24'h0, rows[i].b0}, {24'h0, rx});
            xfer({1'b1, rows[i].ins[14:0]}, 8'h00, 1'b1);
            chk("stream read 1", {24'h0, rows[i].b1}, {24'h0, rx});
        end
        // Buffered write stays hidden until the strobe
        wreg(`SCP_REG_DRIVE, 8'h80);
        chk_bit("drive", 1'b0, drv);
        act(`SCP_REG_DRIVE, 8'h00);
        wreg(`SCP_REG_RBSEL, 8'h20);
        rdreg(`SCP_REG_DRIVE, 8'h80);
        wreg(`SCP_REG_RBSEL, 8'h00);
        rdreg(`SCP_REG_DRIVE, 8'h00);
        wreg(`SCP_REG_XFER, 8'h01);
        upd_exp++;
        chk_bit("drive", 1'b1, drv);
        rdreg(`SCP_REG_XFER, 8'h00);
        wreg(14'h01F0, 8'h00);
        rdreg(14'h01F0, 8'h00);
        chk("updates", upd_exp, upd_n);
        // Update pin only counts when enabled
        wreg(14'h0103, 8'h5C);
        @(posedge ref_clk_i) mp_pin <= 1'b1;
        act(14'h0103, 8'h00);
        @(posedge ref_clk_i) mp_en <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        mp_pin <= 1'b0;
        act(14'h0103, 8'h5C);
        chk_bit("pin update", 1'b1, upd_n > upd_exp);
        // Strap is latched at reset only; undriven line reads high
        rst(1'b1);
        chk_bit("spi active", 1'b0, spi_act);
        cur_cfg = 8'h00;
        rdreg(`SCP_REG_CFG, 8'hFF);
        @(posedge ref_clk_i) strap <= 1'b0;
        repeat (10) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        chk_bit("spi active", 1'b0, spi_act);
        rst(1'b0);
        chk_bit("spi active", 1'b1, spi_act);
        stop_test();
    end

    initial begin
        repeat (80000) @(posedge ref_clk_i);
        n_mismatch++;
        $display("BAD watchdog expected done seen timeout");
        stop_test();
    end
endmodule : tb_top

`default_nettype wire
